// File: rtl/dpc_pkg.sv
// Shared constants, register map and port carriers of the dual-port counter and mailbox block
package dpc_pkg;

   localparam int          ADDR_W        = 18;
   localparam int          DATA_W        = 36;
   localparam int          LANES         = 4;
   localparam int          LANE_W        = 9;
   localparam int          PORTS         = 2;
   localparam int          AXI_AW        = 32;
   localparam int          AXI_DW        = 32;

   // Density codes held in the configuration register
   localparam logic [1:0]  DENS_18       = 2'h0;
   localparam logic [1:0]  DENS_17       = 2'h1;
   localparam logic [1:0]  DENS_16       = 2'h2;
   localparam logic [1:0]  DENS_RESET    = DENS_18;

   // Address width masks per density
   localparam logic [17:0] WMASK_18      = 18'h3FFFF;
   localparam logic [17:0] WMASK_17      = 18'h1FFFF;
   localparam logic [17:0] WMASK_16      = 18'h0FFFF;

   localparam logic [17:0] CNT_RESET     = 18'h00000;
   localparam logic [17:0] MASK_RESET    = 18'h3FFFF;
   localparam logic [17:0] ADDR_ONE      = 18'h00001;

   // Port indices; the right port owns the topmost mailbox
   localparam int          PORT_L        = 0;
   localparam int          PORT_R        = 1;

   // Register byte addresses
   localparam logic [31:0] REG_CONFIG    = 32'h00000000;
   localparam logic [31:0] REG_FLAGS     = 32'h00000004;
   localparam logic [31:0] REG_CNT_L     = 32'h00000008;
   localparam logic [31:0] REG_CNT_R     = 32'h0000000C;
   localparam logic [31:0] REG_MASK_L    = 32'h00000010;
   localparam logic [31:0] REG_MASK_R    = 32'h00000014;

   // Flags register field positions
   localparam int          FLG_MBOX_L    = 0;
   localparam int          FLG_MBOX_R    = 1;
   localparam int          FLG_WRAP_L    = 2;
   localparam int          FLG_WRAP_R    = 3;

   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic [17:0] addr;
      logic        address_strobe_n;
      logic        select_active_low;
      logic        select_active_high;
      logic        counter_advance_n;
      logic        counter_clear_n;
      logic        mask_select_n;
      logic        write_n;
      logic        output_enable_n;
      logic [3:0]  byte_lane_selects_n;
      logic [35:0] dq_in;
   } dpc_port_in_t;

   typedef struct packed {
      logic [35:0] dq_out;
      logic [3:0]  dq_oe;
      logic        mailbox_flag_n;
      logic        wrap_flag_n;
   } dpc_port_out_t;

endpackage : dpc_pkg

// File: rtl/dpc_port_ctrl.sv
// Burst address counter, mask register and wrap flag of one memory port
`timescale 1ns/1ps
module dpc_port_ctrl
   import dpc_pkg::*;
(
   // Clock and resets
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         mreset,
   // Synchronised port controls
   input  wire dpc_port_in_t pin,
   input  wire logic [17:0]  wmask,
   // Results
   output logic [17:0]       eff_addr,
   output logic [17:0]       cnt,
   output logic [17:0]       mask,
   output logic              wrap_flag_n
);

   logic        mask_mode;
   logic        clr;
   logic        ld;
   logic        adv;
   logic [17:0] unm;
   logic [17:0] ext_addr;
   logic [17:0] inc;
   logic [17:0] next_cnt;
   logic [17:0] next_mask;
   logic        next_wrap_n;

   assign mask_mode = ~pin.mask_select_n;
   assign clr       = ~pin.counter_clear_n;
   assign ld        = ~pin.address_strobe_n;
   assign adv       = ~pin.counter_advance_n;
   assign ext_addr  = pin.addr & wmask;
   assign unm       = mask & wmask;
   // Wraps inside the unmasked low field; masked bits stay put
   assign inc       = (((cnt & unm) + ADDR_ONE) & unm) | (cnt & ~unm);

   assign eff_addr  = ld ? ext_addr : cnt;

   assign next_mask = (mask_mode && ld) ? ext_addr : mask;

   // Mask mode holds first, then clear, then load, then advance, else hold
   assign next_cnt  = mask_mode ? cnt :
                      clr       ? (cnt & ~unm) :
                      ld        ? ext_addr :
                      adv       ? inc :
                                  cnt;

   assign next_wrap_n = (!mask_mode && !clr && !ld && adv && ((inc & unm) == unm)) ? 1'b0 :
                        (!mask_mode && (clr || ld)) ? 1'b1 :
                        wrap_flag_n;

   always_ff @(posedge clk_sys) begin
      if (rst || mreset) begin
         cnt         <= CNT_RESET;
         mask        <= MASK_RESET;
         wrap_flag_n <= 1'b1;
      end else begin
         cnt         <= next_cnt;
         mask        <= next_mask;
         wrap_flag_n <= next_wrap_n;
      end
   end

endmodule : dpc_port_ctrl

// File: rtl/dpc_top.sv
// Dual-port counter, mailbox and AXI4-Lite status block
//
// How it works
// - Address width follows density: 18, 17 or 16 bits.
// - Strobe low uses the pin address and loads it into the counter.
// - Port selected only with low select low and high select high.
// - Advance low increments the counter by one each clock.
// - Strobe or clear low suppresses the increment.
// - Clear low zeroes only unmasked counter bits, masked bits kept.
// - Clear wins over strobe and advance in the same cycle.
// - Mask select low makes the mask register the access target.
// - Mask select high: mask untouched, counter follows its controls.
// - Data pins drive read data only while output enable is low.
// - Mailbox flag falls when the other port writes this port's mailbox.
// - Mailbox flag rises when the owning port reads its mailbox.
// - Two top addresses are the mailboxes and still hold data.
// - Topmost address is the right mailbox, one below the left.
// - Wrap flag falls when an increment makes unmasked bits all ones.
// - Master reset: counters zero, masks ones, all flags high.
// - Each byte select gates reads and writes of its lane.
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module dpc_top
   import dpc_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   // Memory port pins, asynchronous to clk_sys
   input  wire logic                   master_reset_n,
   input  wire dpc_port_in_t [1:0]     port_in,
   output dpc_port_out_t [1:0]         port_out,
   // AXI4-Lite write address
   input  wire logic [31:0]            s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [31:0]            s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready
);

   // Pin synchronisers; stage one is read only by stage two
   dpc_port_in_t [1:0] meta_in;
   dpc_port_in_t [1:0] sync_in;
   logic               master_reset_n_meta;
   logic               master_reset_n_sync_n;
   logic               mreset;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         master_reset_n_meta   <= 1'b1;
         master_reset_n_sync_n <= 1'b1;
      end else begin
         master_reset_n_meta   <= master_reset_n;
         master_reset_n_sync_n <= master_reset_n_meta;
      end
   end

   assign mreset = ~master_reset_n_sync_n;

   // Configuration
   logic [1:0]  density;
   logic [17:0] wmask;
   logic [17:0] mbox_addr [PORTS];

   assign wmask = (density == DENS_18) ? WMASK_18 :
                  (density == DENS_17) ? WMASK_17 : WMASK_16;
   assign mbox_addr[PORT_R] = wmask;
   assign mbox_addr[PORT_L] = {wmask[17:1], 1'b0};

   // Per-port decode
   logic [17:0] eff_addr [PORTS];
   logic [17:0] cnt      [PORTS];
   logic [17:0] mask     [PORTS];
   logic        wrap_n   [PORTS];
   logic        sel      [PORTS];
   logic        any_lane [PORTS];
   logic        wr       [PORTS];
   logic        rd       [PORTS];
   logic        hit_own  [PORTS];
   logic        hit_far  [PORTS];
   logic [35:0] lane_bits [PORTS];

   // Mailbox storage and flags
   logic [35:0] mbox   [PORTS];
   logic        mbox_n [PORTS];
   logic [35:0] dq_q   [PORTS];
   logic [3:0]  oe_q   [PORTS];

   genvar gi;
   genvar gl;
   generate
      for (gi = 0; gi < PORTS; gi++) begin : g_port
         always_ff @(posedge clk_sys) begin
            meta_in[gi] <= port_in[gi];
            sync_in[gi] <= meta_in[gi];
         end

         dpc_port_ctrl u_ctrl (
            .clk_sys     (clk_sys),
            .rst         (rst),
            .mreset      (mreset),
            .pin         (sync_in[gi]),
            .wmask       (wmask),
            .eff_addr    (eff_addr[gi]),
            .cnt         (cnt[gi]),
            .mask        (mask[gi]),
            .wrap_flag_n (wrap_n[gi])
         );

         for (gl = 0; gl < LANES; gl++) begin : g_lane
            assign lane_bits[gi][gl*LANE_W +: LANE_W] =
               {LANE_W{~sync_in[gi].byte_lane_selects_n[gl]}};
         end

         assign sel[gi] = ~sync_in[gi].select_active_low &
                          sync_in[gi].select_active_high;
         // Mask accesses never reach the array
         assign any_lane[gi] = ~(&sync_in[gi].byte_lane_selects_n);
         assign wr[gi] = sel[gi] & sync_in[gi].mask_select_n &
                         ~sync_in[gi].write_n & any_lane[gi];
         assign rd[gi] = sel[gi] & sync_in[gi].mask_select_n &
                         sync_in[gi].write_n & any_lane[gi];
         assign hit_own[gi] = (eff_addr[gi] == mbox_addr[gi]);
         assign hit_far[gi] = (eff_addr[gi] == mbox_addr[PORTS-1-gi]);

         always_ff @(posedge clk_sys) begin
            if (rst || mreset) begin
               mbox_n[gi] <= 1'b1;
            end else if (wr[PORTS-1-gi] && hit_far[PORTS-1-gi]) begin
               mbox_n[gi] <= 1'b0;
            end else if (rd[gi] && hit_own[gi]) begin
               mbox_n[gi] <= 1'b1;
            end
         end

         // Read path; off-mailbox words read as zero here
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               dq_q[gi] <= '0;
               oe_q[gi] <= '0;
            end else begin
               dq_q[gi] <= (rd[gi] && (hit_own[gi] || hit_far[gi])) ?
                           ((hit_own[gi] ? mbox[gi] : mbox[PORTS-1-gi]) & lane_bits[gi]) :
                           '0;
               oe_q[gi] <= (rd[gi] && !sync_in[gi].output_enable_n) ?
                           ~sync_in[gi].byte_lane_selects_n : '0;
            end
         end

         assign port_out[gi] = '{dq_out:         dq_q[gi],
                                 dq_oe:          oe_q[gi],
                                 mailbox_flag_n: mbox_n[gi],
                                 wrap_flag_n:    wrap_n[gi]};
      end
   endgenerate

   // Mailbox words; same-word collisions are undefined, right port wins
   logic [35:0] next_mbox [PORTS];

   always_comb begin
      for (int m = 0; m < PORTS; m++) begin
         next_mbox[m] = mbox[m];
         for (int p = 0; p < PORTS; p++) begin
            if (wr[p] && (eff_addr[p] == mbox_addr[m])) begin
               next_mbox[m] = (next_mbox[m] & ~lane_bits[p]) |
                              (sync_in[p].dq_in & lane_bits[p]);
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mbox[PORT_L] <= '0;
         mbox[PORT_R] <= '0;
      end else begin
         mbox[PORT_L] <= next_mbox[PORT_L];
         mbox[PORT_R] <= next_mbox[PORT_R];
      end
   end

   // AXI4-Lite write side: address and data taken in either order
   logic        aw_take;
   logic        w_take;
   logic        wr_go;
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_map;

   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take  = s_axi_wvalid & s_axi_wready;
   assign wr_go   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   assign wr_map  = (aw_addr == REG_CONFIG) || (aw_addr == REG_FLAGS) ||
                    (aw_addr == REG_CNT_L)  || (aw_addr == REG_CNT_R) ||
                    (aw_addr == REG_MASK_L) || (aw_addr == REG_MASK_R);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_addr       <= '0;
         w_data        <= '0;
         w_strb        <= '0;
         density       <= DENS_RESET;
      end else begin
         if (aw_take) begin
            s_axi_awready <= 1'b0;
            aw_addr       <= s_axi_awaddr;
         end
         if (w_take) begin
            s_axi_wready <= 1'b0;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
            if ((aw_addr == REG_CONFIG) && w_strb[0]) begin
               density <= w_data[1:0];
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // AXI4-Lite read side: answer one cycle after the address is taken
   logic [31:0] rd_mux;
   logic        rd_map;
   logic [31:0] flag_word;

   assign flag_word = {28'h0000000, wrap_n[PORT_R], wrap_n[PORT_L],
                       mbox_n[PORT_R], mbox_n[PORT_L]};
   assign rd_map = (s_axi_araddr == REG_CONFIG) || (s_axi_araddr == REG_FLAGS) ||
                   (s_axi_araddr == REG_CNT_L)  || (s_axi_araddr == REG_CNT_R) ||
                   (s_axi_araddr == REG_MASK_L) || (s_axi_araddr == REG_MASK_R);
   assign rd_mux = (s_axi_araddr == REG_CONFIG) ? {30'h00000000, density} :
                   (s_axi_araddr == REG_FLAGS)  ? flag_word :
                   (s_axi_araddr == REG_CNT_L)  ? {14'h0000, cnt[PORT_L]} :
                   (s_axi_araddr == REG_CNT_R)  ? {14'h0000, cnt[PORT_R]} :
                   (s_axi_araddr == REG_MASK_L) ? {14'h0000, mask[PORT_L]} :
                   (s_axi_araddr == REG_MASK_R) ? {14'h0000, mask[PORT_R]} :
                                                  32'h00000000;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_map ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule : dpc_top

// File: verif/dpc_pin_master.sv
// Behavioural bus master on one memory port's pins
`timescale 1ns/1ps
module dpc_pin_master
   import dpc_pkg::*;
(
   // Clock
   input  wire logic clk_sys,
   // Port pins
   output dpc_port_in_t pin
);
   dpc_port_in_t cmd;
   int           cnt = 0;
   // Idle: deselected, controls off, address and data churn so stale values never match
   function automatic dpc_port_in_t idle_pins();
      dpc_port_in_t v;
      v = '1;
      v.select_active_high = 1'b0;
      v.addr = 18'($urandom);
      v.dq_in = {$urandom, 4'h3};
      return v;
   endfunction : idle_pins
   initial pin = idle_pins();
   always @(posedge clk_sys) begin
      if (cnt > 0) begin
         pin <= cmd;
         cnt <= cnt - 1;
      end else begin
         pin <= idle_pins();
      end
   end
   task automatic apply(input dpc_port_in_t v, input int n);
      @(negedge clk_sys);
      cmd = v;
      cnt = n;
      repeat (n) @(posedge clk_sys);
   endtask : apply
endmodule : dpc_pin_master

// File: verif/dpc_props.sv
// Concurrent checks on the ports of the dual-port counter and mailbox block
`timescale 1ns/1ps
module dpc_props
   import dpc_pkg::*;
(
   // Clock and resets
   input wire logic                clk_sys,
   input wire logic                rst,
   input wire logic                master_reset_n,
   // Memory ports
   input wire dpc_port_in_t [1:0]  port_in,
   input wire dpc_port_out_t [1:0] port_out,
   // Bus handshakes
   input wire logic                s_axi_awready,
   input wire logic                s_axi_wready,
   input wire logic [1:0]          s_axi_bresp,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_bready,
   input wire logic                s_axi_arready,
   input wire logic [31:0]         s_axi_rdata,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_rready
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic [4:0] master_reset_n_hist;
   always_ff @(posedge clk_sys) master_reset_n_hist <= {master_reset_n_hist[3:0], ~master_reset_n};
   // Pin address is not checked: counter-addressed accesses never show it
   function automatic logic acc(dpc_port_in_t v);
      return !v.select_active_low && v.select_active_high && v.byte_lane_selects_n != 4'hF;
   endfunction : acc
   sequence master_reset_n_held_s;
      !master_reset_n [*5];
   endsequence
   sequence r_wait_s;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (r_wait_s |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   mbox_set_a: assert property ($fell(port_out[PORT_R].mailbox_flag_n) |->
      $past(acc(port_in[PORT_L]) && !port_in[PORT_L].write_n, 3))
      else $error("right mail flag fell without left write");
   mbox_clr_a: assert property ($rose(port_out[PORT_R].mailbox_flag_n) |->
      $past(acc(port_in[PORT_R]) && port_in[PORT_R].write_n, 3) || (|master_reset_n_hist))
      else $error("right mail flag rose without right read");
   master_reset_n_flags_a: assert property (master_reset_n_held_s |=> port_out[0].mailbox_flag_n &&
      port_out[1].mailbox_flag_n && port_out[0].wrap_flag_n && port_out[1].wrap_flag_n)
      else $error("flags not high after master reset");
   oe_gate_a: assert property ((port_out[0].dq_oe == 4'h0 ||
      !$past(port_in[0].output_enable_n, 3)) && (port_out[1].dq_oe == 4'h0 ||
      !$past(port_in[1].output_enable_n, 3)))
      else $error("data driven without output enable");
   wrap_fall_a: assert property ($fell(port_out[PORT_L].wrap_flag_n) |->
      $past(!port_in[PORT_L].counter_advance_n && port_in[PORT_L].counter_clear_n &&
      port_in[PORT_L].address_strobe_n && port_in[PORT_L].mask_select_n, 3))
      else $error("wrap flag fell without an increment");
   wrap_rise_a: assert property ($rose(port_out[PORT_L].wrap_flag_n) |->
      $past(!port_in[PORT_L].counter_clear_n || !port_in[PORT_L].address_strobe_n, 3) ||
      (|master_reset_n_hist))
      else $error("wrap flag rose without clear or load");
endmodule : dpc_props

// File: verif/tb.sv
// Self-checking bench for the dual-port counter and mailbox block
`timescale 1ns/1ps
module tb;
   import dpc_pkg::*;
   localparam logic [6:0] WR = 7'h40, OE = 7'h20, LD = 7'h10, ADV = 7'h08;
   localparam logic [6:0] CLR = 7'h04, MSK = 7'h02, SEL = 7'h01;
   logic                clk_sys = 1'b0;
   logic                rst = 1'b1;
   logic                master_reset_n = 1'b1;
   dpc_port_in_t        pin_l, pin_r, v;
   dpc_port_out_t [1:0] port_out;
   logic [31:0]         s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
   logic [3:0]          s_axi_wstrb = 4'hF;
   logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]          s_axi_bresp, s_axi_rresp;
   logic [17:0]         a, b, m, c;
   logic [35:0]         d;
   int                  fails = 0, total_checks = 0, k, n;
   logic [31:0]         rv [6] = '{32'h0, 32'hF, 32'h0, 32'h0, 32'h3FFFF, 32'h3FFFF};
   logic [17:0]         wm [3] = '{WMASK_18, WMASK_17, WMASK_16};
   always #10 clk_sys = ~clk_sys;
   dpc_top DUT (.clk_sys, .rst, .master_reset_n, .port_in({pin_r, pin_l}), .port_out,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   dpc_pin_master m_l (.clk_sys, .pin(pin_l));
   dpc_pin_master m_r (.clk_sys, .pin(pin_r));
   function automatic dpc_port_in_t op(logic [17:0] ad, logic [6:0] c7, logic [35:0] dd);
      dpc_port_in_t r;
      r = '1;
      r.addr = ad;
      r.dq_in = dd;
      {r.write_n, r.output_enable_n, r.address_strobe_n, r.counter_advance_n} = ~c7[6:3];
      {r.counter_clear_n, r.mask_select_n, r.select_active_low} = ~c7[2:0];
      r.select_active_high = c7[0];
      r.byte_lane_selects_n = {4{~c7[0]}};
      return r;
   endfunction : op
   // Increment inside the unmasked field only; masked bits never move
   function automatic logic [17:0] nxt(logic [17:0] x, logic [17:0] mk, int j);
      return (x & ~mk) | ((x + 18'(j)) & mk);
   endfunction : nxt
   function automatic logic wexp(logic [17:0] x, logic [17:0] mk, int j);
      logic w;
      w = 1'b1;
      repeat (j) begin
         x = nxt(x, mk, 1);
         if ((x & mk) == mk) w = 1'b0;
      end
      return w;
   endfunction : wexp
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [31:0] ad, input logic [31:0] dd, input logic [1:0] er);
      int i;
      @(posedge clk_sys);
      s_axi_awaddr <= ad;
      s_axi_wdata <= dd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'($urandom % 2);
      for (i = 0; i < 200; i++) begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (i == 3) s_axi_bready <= 1'b1;
         if (s_axi_bready && s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            chk("bresp", er, s_axi_bresp);
            break;
         end
      end
      if (i == 200) chk("write wait", 36'h1, 36'h0);
      if (i == 200) tally_and_finish();
   endtask : wr
   task automatic rd(input logic [31:0] ad, input logic [31:0] e, input logic [1:0] er);
      int i;
      @(posedge clk_sys);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'($urandom % 2);
      for (i = 0; i < 200; i++) begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (i == 3) s_axi_rready <= 1'b1;
         if (s_axi_rready && s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            chk("rdata", e, s_axi_rdata);
            chk("rresp", er, s_axi_rresp);
            break;
         end
      end
      if (i == 200) chk("read wait", 36'h1, 36'h0);
      if (i == 200) tally_and_finish();
   endtask : rd
   // Pins need two sync edges plus one result edge
   task automatic go(input int p, input dpc_port_in_t pv, input int cnt);
      if (p == PORT_R) m_r.apply(pv, cnt);
      else m_l.apply(pv, cnt);
      repeat (4) @(posedge clk_sys);
   endtask : go
   initial begin
      void'($urandom(23983));
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      for (k = 0; k < 6; k++) rd(REG_CONFIG + 4 * k, rv[k], RESP_OKAY);
      wr(REG_CNT_L, 32'h15, RESP_OKAY);
      rd(REG_CNT_L, 32'h0, RESP_OKAY);
      wr(32'h40, 32'h1, RESP_SLVERR);
      rd(32'h40, 32'h0, RESP_SLVERR);
      s_axi_wstrb <= 4'h0;
      wr(REG_CONFIG, 32'h1, RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rd(REG_CONFIG, 32'h0, RESP_OKAY);
      a = 18'($urandom);
      b = ~a;
      go(PORT_L, op(a, LD, '0), 1);
      rd(REG_CNT_L, a, RESP_OKAY);
      go(PORT_R, op(b, LD, '0), 1);
      rd(REG_CNT_R, b, RESP_OKAY);
      n = 1 + $urandom % 20;
      go(PORT_L, op(a, ADV, '0), n);
      rd(REG_CNT_L, nxt(a, MASK_RESET, n), RESP_OKAY);
      repeat (20) @(posedge clk_sys);
      rd(REG_CNT_L, nxt(a, MASK_RESET, n), RESP_OKAY);
      go(PORT_L, op(b, LD | ADV, '0), 3);
      rd(REG_CNT_L, b, RESP_OKAY);
      go(PORT_L, op(a, LD | ADV | CLR, '0), 2);
      rd(REG_CNT_L, 32'h0, RESP_OKAY);
      for (k = 0; k < 8; k++) begin
         m = 18'h3FFFF >> (13 + $urandom % 5);
         a = 18'($urandom);
         n = 1 + $urandom % 12;
         go(PORT_L, op(m, MSK | LD, '0), 1);
         rd(REG_MASK_L, m, RESP_OKAY);
         go(PORT_L, op(a, LD, '0), 1);
         go(PORT_L, op(a, ADV, '0), n);
         rd(REG_CNT_L, nxt(a, m, n), RESP_OKAY);
         chk("wrap_l", wexp(a, m, n), port_out[0].wrap_flag_n);
      end
      c = nxt(a, m, n);
      go(PORT_L, op(a, MSK | ADV | CLR, '0), 3);
      rd(REG_CNT_L, c, RESP_OKAY);
      rd(REG_MASK_L, m, RESP_OKAY);
      go(PORT_L, op(a, CLR, '0), 1);
      rd(REG_CNT_L, c & ~m, RESP_OKAY);
      chk("wrap_l", 36'h1, port_out[0].wrap_flag_n);
      for (k = 0; k < 3; k++) begin
         wr(REG_CONFIG, 32'(k), RESP_OKAY);
         go(PORT_R, op(18'h3FFFF, LD, '0), 1);
         rd(REG_CNT_R, wm[k], RESP_OKAY);
      end
      wr(REG_CONFIG, 32'(DENS_18), RESP_OKAY);
      d = {$urandom, 4'h9};
      for (k = 0; k < 3; k++) begin
         v = op(18'h3FFFF, WR | LD | SEL, d);
         if (k == 0) v.select_active_high = 1'b0;
         if (k == 1) v.select_active_low = 1'b1;
         if (k == 2) v.byte_lane_selects_n = 4'hF;
         go(PORT_L, v, 1);
         chk("mbox_r", 36'h1, port_out[1].mailbox_flag_n);
      end
      go(PORT_L, op(18'h3FFFF, WR | LD | SEL, d), 1);
      rd(REG_FLAGS, 32'hD, RESP_OKAY);
      go(PORT_L, op(18'h3FFFF, OE | LD | SEL, '0), 1);
      chk("mbox_r", 36'h0, port_out[1].mailbox_flag_n);
      m_r.apply(op(18'h3FFFF, OE | LD | SEL, '0), 5);
      #1;
      chk("dq_r", d, port_out[1].dq_out);
      chk("oe_r", 36'hF, port_out[1].dq_oe);
      repeat (5) @(posedge clk_sys);
      chk("oe_r", 36'h0, port_out[1].dq_oe);
      chk("mbox_r", 36'h1, port_out[1].mailbox_flag_n);
      go(PORT_R, op(18'h3FFFE, WR | LD | SEL, ~d), 1);
      v = op(18'h3FFFE, WR | LD | SEL, d);
      v.byte_lane_selects_n = 4'hE;
      go(PORT_R, v, 1);
      chk("mbox_l", 36'h0, port_out[0].mailbox_flag_n);
      m_l.apply(op(18'h3FFFE, OE | LD | SEL, '0), 5);
      #1;
      chk("dq_l", {~d[35:9], d[8:0]}, port_out[0].dq_out);
      chk("oe_l", 36'hF, port_out[0].dq_oe);
      repeat (4) @(posedge clk_sys);
      chk("mbox_l", 36'h1, port_out[0].mailbox_flag_n);
      go(PORT_R, op(18'h3FFFE, WR | LD | SEL, d), 1);
      master_reset_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      master_reset_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      for (k = 1; k < 6; k++) rd(REG_CONFIG + 4 * k, rv[k], RESP_OKAY);
      tally_and_finish();
   end
endmodule : tb
bind dpc_top dpc_props u_props (.clk_sys, .rst, .master_reset_n, .port_in, .port_out,
   .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
